// File: sbc_pkg.sv
// Package: register map, field layout and rate constants of the serial block
// Summary of operation
// - Receiver idle while enable is 0; when 1 it hunts for a start bit.
// - Mute bit is software writable; hardware clears it on a wake-up sequence.
// - Break characters are sent while send-break is 1, and one more after it is cleared.
// - Setting then clearing send-break sends one break after the current word.
// - Data address holds separate transmit and receive holding buffers.
// - Coarse prescaler bits 7:6 divide by 1, 3, 4 or 13.
// - Transmit divisor bits 5:3 divide by two to the field value.
// - Receive divisor bits 2:0 divide by two to the field value.
// - Power-of-two transmit divisor used only while transmit fine divider is zero.
// - Power-of-two receive divisor used only while receive fine divider is zero.
// - Nonzero receive fine value divides the divide-by-16 output for reception.
// - Nonzero transmit fine value divides the divide-by-16 output for transmission.
// - Both fine dividers read zero after reset.
// - Coarse prescaler bits reset to zero; divisor fields reset unspecified.
// - While muted no receive flag is set, except by the address word that ends the mute.
// - Wake on idle line (method 0) or on an address word with top bit set (method 1).
// - Extended rate equals clock divided by 16 and the fine value.
package sbc_pkg;
    // Register indices (word offsets) of the registers
    localparam logic [7:0] SBC_STATUS_ADDR = 8'h50;
    localparam logic [7:0] SBC_DATA_ADDR = 8'h51;
    localparam logic [7:0] SBC_BAUD_ADDR = 8'h52;
    localparam logic [7:0] SBC_FRAME_ADDR = 8'h53;
    localparam logic [7:0] SBC_CTRL_ADDR = 8'h54;
    localparam logic [7:0] SBC_RXFINE_ADDR = 8'h55;
    localparam logic [7:0] SBC_TXFINE_ADDR = 8'h57;
    // Register indices equal printed offsets; byte address is four times
    localparam int SBC_ADDR_SHIFT = 2;
    // Control register fields
    localparam int SBC_CTL_TE = 3;
    localparam int SBC_CTL_RE = 2;
    localparam int SBC_CTL_MUTE = 1;
    localparam int SBC_CTL_BRK = 0;
    // Frame register fields
    localparam int SBC_FRM_R8 = 7;
    localparam int SBC_FRM_T8 = 6;
    localparam int SBC_FRM_M = 4;
    localparam int SBC_FRM_WAKE = 3;
    localparam logic [7:0] SBC_FRM_MASK = 8'h58;
    // Status fields
    localparam int SBC_ST_TXE = 7;
    localparam int SBC_ST_TC = 6;
    localparam int SBC_ST_RXF = 5;
    localparam int SBC_ST_IDLE = 4;
    localparam int SBC_ST_OR = 3;
    localparam int SBC_ST_FE = 1;
    // Reset values
    localparam logic [7:0] SBC_CTRL_RST = 8'h00;
    localparam logic [7:0] SBC_BAUD_RST = 8'h00;
    localparam logic [7:0] SBC_FINE_RST = 8'h00;
    localparam logic [7:0] SBC_FRAME_RST = 8'h00;
    // Oversampling stage and coarse factors
    localparam int SBC_OVERSAMPLE = 16;
    localparam logic [3:0] SBC_PRE_F0 = 4'h1;
    localparam logic [3:0] SBC_PRE_F1 = 4'h3;
    localparam logic [3:0] SBC_PRE_F2 = 4'h4;
    localparam logic [3:0] SBC_PRE_F3 = 4'hd;
    localparam int SBC_FIFO_DEPTH = 8;
    // Register write carrier
    typedef struct packed {
        logic valid;
        logic [7:0] addr;
        logic [7:0] data;
    } sbc_wr_t;
    // Transmitter states
    typedef enum logic [1:0] {SBC_TX_IDLE, SBC_TX_SHIFT, SBC_TX_BREAK} sbc_tx_state_t;
endpackage

// File: sbc_fifo.sv
// Small synchronous FIFO with valid/ready on both sides
`timescale 1ns/1ps
module sbc_fifo #(
    parameter int WIDTH = 9,
    parameter int DEPTH = 8
) (
    // Clock and reset
    input wire logic pclk,
    input wire logic presetn,
    // Fill side
    input wire logic in_valid,
    output logic in_ready,
    input wire logic [WIDTH-1:0] in_data,
    // Drain side
    output logic out_valid,
    input wire logic out_ready,
    output logic [WIDTH-1:0] out_data
);
    localparam int AW = $clog2(DEPTH);
    logic [WIDTH-1:0] mem_q [DEPTH];
    logic [AW-1:0] wr_q;
    logic [AW-1:0] rd_q;
    logic [AW:0] cnt_q;
    logic push;
    logic pop;

    // Handshakes
    assign in_ready = (cnt_q != (AW+1)'(DEPTH));
    assign out_valid = (cnt_q != '0);
    assign push = in_valid && in_ready;
    assign pop = out_valid && out_ready;

    // Storage, no reset needed on data
    always_ff @(posedge pclk) begin
        if (push) begin
            mem_q[wr_q] <= in_data;
        end
    end

    // Registered read data at head
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            out_data <= '0;
        end else if (pop && cnt_q > (AW+1)'(1)) begin
            out_data <= mem_q[AW'(rd_q + AW'(1))];
        end else if (push && (cnt_q == '0 || (pop && cnt_q == (AW+1)'(1)))) begin
            out_data <= in_data;
        end
    end

    // Pointers and fill count
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            wr_q <= '0;
            rd_q <= '0;
            cnt_q <= '0;
        end else begin
            if (push) begin
                wr_q <= (wr_q == AW'(DEPTH-1)) ? '0 : AW'(wr_q + AW'(1));
            end
            if (pop) begin
                rd_q <= (rd_q == AW'(DEPTH-1)) ? '0 : AW'(rd_q + AW'(1));
            end
            cnt_q <= (AW+1)'(cnt_q + (AW+1)'(push) - (AW+1)'(pop));
        end
    end
endmodule

// File: sbc_serial.sv
// Serial block: APB registers, baud generator, transmitter and receiver
`timescale 1ns/1ps
module sbc_serial
    import sbc_pkg::*;
#(
    parameter int FIFO_DEPTH = SBC_FIFO_DEPTH
) (
    // APB clock and reset
    input wire logic pclk,
    input wire logic presetn,
    // APB slave
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    // Serial line
    input wire logic rxd,
    output logic txd
);
    ////////////////////////////////////////////////////////////////////////
    // Register access
    logic [7:0] ctrl_q;
    logic [7:0] baud_q;
    logic [7:0] frame_q;
    logic [7:0] rx_fine_divider_q;
    logic [7:0] tx_fine_divider_q;
    logic [7:0] rx_holding_buffer_q;
    logic rx_full_flag_q;
    logic idle_q;
    logic ovr_q;
    logic fe_q;
    logic tc_q;
    logic st_seen_q;
    sbc_wr_t wr;
    logic rd_en;
    logic [7:0] reg_idx;
    logic addr_ok;
    logic fifo_ready;
    logic fifo_valid;
    logic [8:0] fifo_data;
    logic fifo_pop;
    logic wake_idle;
    logic wake_addr;
    logic rx_done;
    logic [8:0] rx_word;
    logic rx_ferr;

    assign reg_idx = paddr[9:2];
    assign addr_ok = (paddr[1:0] == 2'b00) && (paddr[11:10] == 2'b00) &&
        (reg_idx inside {SBC_STATUS_ADDR, SBC_DATA_ADDR, SBC_BAUD_ADDR, SBC_FRAME_ADDR,
        SBC_CTRL_ADDR, SBC_RXFINE_ADDR, SBC_TXFINE_ADDR});
    // Zero wait states: every access completes in its access phase
    assign pready = 1'b1;
    assign pslverr = psel && penable && !addr_ok;
    assign wr.valid = psel && penable && pwrite && addr_ok;
    assign wr.addr = reg_idx;
    assign wr.data = pwdata[7:0];
    assign rd_en = psel && penable && !pwrite && addr_ok;

    function automatic logic wr_hit(input sbc_wr_t w, input logic [7:0] a);
        return w.valid && (w.addr == a);
    endfunction

    // Control registers; hardware wake-up clears mute, wake wins over a write
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            ctrl_q <= SBC_CTRL_RST;
            baud_q <= SBC_BAUD_RST;
            frame_q <= SBC_FRAME_RST;
            rx_fine_divider_q <= SBC_FINE_RST;
            tx_fine_divider_q <= SBC_FINE_RST;
        end else begin
            if (wr_hit(wr, SBC_CTRL_ADDR)) begin
                ctrl_q <= wr.data;
            end
            if (wake_idle || wake_addr) begin
                ctrl_q[SBC_CTL_MUTE] <= 1'b0;
            end
            if (wr_hit(wr, SBC_BAUD_ADDR)) begin
                baud_q <= wr.data;
            end
            if (wr_hit(wr, SBC_FRAME_ADDR)) begin
                frame_q <= wr.data & (SBC_FRM_MASK | 8'h80);
            end
            if (rx_done) begin
                frame_q[SBC_FRM_R8] <= rx_word[8];
            end
            if (wr_hit(wr, SBC_RXFINE_ADDR)) begin
                rx_fine_divider_q <= wr.data;
            end
            if (wr_hit(wr, SBC_TXFINE_ADDR)) begin
                tx_fine_divider_q <= wr.data;
            end
        end
    end

    // Read mux, registered data output
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            prdata <= '0;
        end else if (psel && !penable && !pwrite) begin
            case (reg_idx)
                SBC_STATUS_ADDR: prdata <= {24'h0, fifo_ready, tc_q, rx_full_flag_q, idle_q,
                    ovr_q, 1'b0, fe_q, 1'b0};
                SBC_DATA_ADDR: prdata <= {24'h0, rx_holding_buffer_q};
                SBC_BAUD_ADDR: prdata <= {24'h0, baud_q};
                SBC_FRAME_ADDR: prdata <= {24'h0, frame_q};
                SBC_CTRL_ADDR: prdata <= {24'h0, ctrl_q};
                SBC_RXFINE_ADDR: prdata <= {24'h0, rx_fine_divider_q};
                SBC_TXFINE_ADDR: prdata <= {24'h0, tx_fine_divider_q};
                default: prdata <= '0;
            endcase
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Baud generator: prescale then power-of-two divider, or fine divider alone
    function automatic logic [3:0] pre_factor(input logic [1:0] code);
        case (code)
            2'b00: return SBC_PRE_F0;
            2'b01: return SBC_PRE_F1;
            2'b10: return SBC_PRE_F2;
            default: return SBC_PRE_F3;
        endcase
    endfunction

    // Oversample tick period: prescale * 2^n, or the fine value in fine mode
    function automatic logic [11:0] tick_period(input logic [1:0] pre, input logic [2:0] pw,
        input logic [7:0] fine);
        if (fine != 8'h00) begin
            return {4'h0, fine};
        end
        return 12'(pre_factor(pre)) << pw;
    endfunction

    // The 16x stage runs from pclk in fine mode so rate is pclk/16/fine
    logic [11:0] tx_per;
    logic [11:0] rx_per;
    logic [11:0] tx_cnt_q;
    logic [11:0] rx_cnt_q;
    logic tx_tick;
    logic rx_tick;
    assign tx_per = tick_period(baud_q[7:6], baud_q[5:3], tx_fine_divider_q);
    assign rx_per = tick_period(baud_q[7:6], baud_q[2:0], rx_fine_divider_q);
    assign tx_tick = (tx_cnt_q >= tx_per - 12'h001);
    assign rx_tick = (rx_cnt_q >= rx_per - 12'h001);

    // Rate counters; reset hunt phase when receiver disabled
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            tx_cnt_q <= '0;
            rx_cnt_q <= '0;
        end else begin
            tx_cnt_q <= tx_tick ? 12'h000 : 12'(tx_cnt_q + 12'h001);
            rx_cnt_q <= (rx_tick || !ctrl_q[SBC_CTL_RE]) ? 12'h000 : 12'(rx_cnt_q + 12'h001);
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Transmit FIFO in front of the holding path
    logic tx_push;
    assign tx_push = wr_hit(wr, SBC_DATA_ADDR);
    sbc_fifo #(.WIDTH(9), .DEPTH(FIFO_DEPTH)) u_txf (
        .pclk(pclk),
        .presetn(presetn),
        .in_valid(tx_push),
        .in_ready(fifo_ready),
        .in_data({frame_q[SBC_FRM_T8], wr.data}),
        .out_valid(fifo_valid),
        .out_ready(fifo_pop),
        .out_data(fifo_data)
    );

    ////////////////////////////////////////////////////////////////////////
    // Transmitter
    sbc_tx_state_t tx_st_q;
    logic [10:0] tx_sh_q;
    logic [3:0] tx_bits_q;
    logic [3:0] tx_os_q;
    logic brk_prev_q;
    logic brk_pend_q;
    logic tx_on;
    assign tx_on = ctrl_q[SBC_CTL_TE];
    // Pop only when shifter is idle and no break is owed
    assign fifo_pop = (tx_st_q == SBC_TX_IDLE) && tx_on && fifo_valid &&
        !ctrl_q[SBC_CTL_BRK] && !brk_pend_q;

    // Break pending on falling edge of send-break; held until the idle shifter takes it
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            brk_prev_q <= 1'b0;
            brk_pend_q <= 1'b0;
        end else begin
            brk_prev_q <= ctrl_q[SBC_CTL_BRK];
            if (brk_prev_q && !ctrl_q[SBC_CTL_BRK]) begin
                brk_pend_q <= 1'b1;
            end else if (tx_st_q == SBC_TX_IDLE && tx_on) begin
                brk_pend_q <= 1'b0;
            end
        end
    end

    // Shifter: start, data (8 or 9), stop; a break is all zeros
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            tx_st_q <= SBC_TX_IDLE;
            tx_sh_q <= '1;
            tx_bits_q <= '0;
            tx_os_q <= '0;
            tc_q <= 1'b1;
        end else begin
            case (tx_st_q)
                SBC_TX_IDLE: begin
                    tx_os_q <= '0;
                    if (tx_on && (ctrl_q[SBC_CTL_BRK] || brk_pend_q)) begin
                        tx_st_q <= SBC_TX_BREAK;
                        tx_sh_q <= '0;
                        tx_bits_q <= frame_q[SBC_FRM_M] ? 4'ha : 4'h9;
                        tc_q <= 1'b0;
                    end else if (fifo_pop) begin
                        tx_st_q <= SBC_TX_SHIFT;
                        tx_sh_q <= frame_q[SBC_FRM_M] ? {1'b1, fifo_data, 1'b0}
                            : {2'b11, fifo_data[7:0], 1'b0};
                        tx_bits_q <= frame_q[SBC_FRM_M] ? 4'ha : 4'h9;
                        tc_q <= 1'b0;
                    end
                end
                SBC_TX_SHIFT, SBC_TX_BREAK: begin
                    if (tx_tick) begin
                        tx_os_q <= 4'(tx_os_q + 4'h1);
                        if (tx_os_q == 4'hf) begin
                            tx_sh_q <= {(tx_st_q == SBC_TX_SHIFT), tx_sh_q[10:1]};
                            if (tx_bits_q == 4'h0) begin
                                tx_st_q <= SBC_TX_IDLE;
                                tc_q <= 1'b1;
                            end else begin
                                tx_bits_q <= 4'(tx_bits_q - 4'h1);
                            end
                        end
                    end
                end
                default: tx_st_q <= SBC_TX_IDLE;
            endcase
        end
    end

    // Line drive registered; idle high, break low
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            txd <= 1'b1;
        end else begin
            txd <= (tx_st_q == SBC_TX_SHIFT) ? tx_sh_q[0] : !(tx_st_q == SBC_TX_BREAK ||
                (tx_on && (ctrl_q[SBC_CTL_BRK] || brk_pend_q)));
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Receiver: 16x oversampling, mid-bit sample
    logic rx_busy_q;
    logic [3:0] rx_os_q;
    logic [3:0] rx_bit_q;
    logic [8:0] rx_sh_q;
    logic [3:0] idle_cnt_q;
    logic idle_armed_q;
    logic [3:0] rx_last;
    logic muted;
    assign muted = ctrl_q[SBC_CTL_MUTE];
    assign rx_last = frame_q[SBC_FRM_M] ? 4'ha : 4'h9;
    assign rx_done = rx_busy_q && rx_tick && rx_os_q == 4'h7 && rx_bit_q == rx_last && !muted;
    assign rx_word = frame_q[SBC_FRM_M] ? rx_sh_q : {1'b0, rx_sh_q[8:1]};
    assign rx_ferr = !rxd;
    // Address mark: top data bit set ends the mute
    assign wake_addr = muted && rx_busy_q && rx_tick && rx_os_q == 4'h7 &&
        rx_bit_q == rx_last && frame_q[SBC_FRM_WAKE] &&
        rx_sh_q[8];
    // Idle frame: line high for a whole frame of bit times
    assign wake_idle = muted && !frame_q[SBC_FRM_WAKE] && !rx_busy_q && rx_tick &&
        rx_os_q == 4'hf && idle_cnt_q == rx_last;

    // Bit framing; disabled receiver stays idle
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            rx_busy_q <= 1'b0;
            rx_os_q <= '0;
            rx_bit_q <= '0;
            rx_sh_q <= '0;
            idle_cnt_q <= '0;
        end else if (!ctrl_q[SBC_CTL_RE]) begin
            rx_busy_q <= 1'b0;
            rx_os_q <= '0;
            idle_cnt_q <= '0;
        end else if (rx_tick) begin
            rx_os_q <= 4'(rx_os_q + 4'h1);
            if (!rx_busy_q) begin
                if (!rxd) begin
                    rx_busy_q <= 1'b1;
                    rx_os_q <= 4'h1;
                    rx_bit_q <= '0;
                    idle_cnt_q <= '0;
                end else if (rx_os_q == 4'hf && idle_cnt_q != 4'hf) begin
                    idle_cnt_q <= 4'(idle_cnt_q + 4'h1);
                end
            end else if (rx_os_q == 4'h7) begin
                if (rx_bit_q == 4'h0 && rxd) begin
                    rx_busy_q <= 1'b0; // False start
                end else if (rx_bit_q == rx_last) begin
                    rx_busy_q <= 1'b0;
                end else begin
                    if (rx_bit_q != 4'h0) begin
                        rx_sh_q <= {rxd, rx_sh_q[8:1]};
                    end
                    rx_bit_q <= 4'(rx_bit_q + 4'h1);
                end
            end
        end
    end

    // Status: hardware set wins over software clear; no flags while muted except from the address word that wakes it
    logic rx_clr;
    logic idle_hit;
    assign rx_clr = st_seen_q && rd_en && reg_idx == SBC_DATA_ADDR;
    assign idle_hit = !muted && idle_armed_q && !rx_busy_q && rx_tick && rx_os_q == 4'hf &&
        idle_cnt_q == rx_last;
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            rx_holding_buffer_q <= '0;
            rx_full_flag_q <= 1'b0;
            idle_q <= 1'b0;
            ovr_q <= 1'b0;
            fe_q <= 1'b0;
            st_seen_q <= 1'b0;
            idle_armed_q <= 1'b0;
        end else begin
            if (rd_en && reg_idx == SBC_STATUS_ADDR) begin
                st_seen_q <= 1'b1;
            end else if (rx_clr) begin
                st_seen_q <= 1'b0;
            end
            if (rx_clr) begin
                rx_full_flag_q <= 1'b0;
                idle_q <= 1'b0;
                ovr_q <= 1'b0;
                fe_q <= 1'b0;
            end
            if (rx_done || wake_addr) begin
                idle_armed_q <= 1'b1;
                if (rx_full_flag_q && !rx_clr) begin
                    ovr_q <= 1'b1;
                end else begin
                    rx_holding_buffer_q <= rx_word[7:0];
                    rx_full_flag_q <= 1'b1;
                    fe_q <= rx_ferr;
                end
            end
            if (idle_hit) begin
                idle_q <= 1'b1;
                idle_armed_q <= 1'b0;
            end
        end
    end
endmodule

// File: sbc_serial_assertions.sv
// Checker: port-level assertions for the serial block
`timescale 1ns/1ps
module sbc_serial_assertions
    import sbc_pkg::*;
#(
    parameter int FIFO_DEPTH = SBC_FIFO_DEPTH
) (
    // APB side
    input wire logic pclk,
    input wire logic presetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] pwdata,
    input wire logic [31:0] prdata,
    input wire logic pready,
    input wire logic pslverr,
    // Serial line
    input wire logic rxd,
    input wire logic txd
);
    default clocking @(posedge pclk); endclocking
    default disable iff (!presetn);
    logic acc;
    logic rd;
    logic [7:0] rxf_q;
    logic [7:0] txf_q;
    logic [1:0] pre_q;
    ////////////////////////////////////////////////////////////////////////////////
    // Access phase decode
    assign acc = psel && penable;
    assign rd = acc && !pwrite;
    // Shadow of the written rate settings, starting from reset values
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            rxf_q <= 8'h00;
            txf_q <= 8'h00;
            pre_q <= 2'b00;
        end else if (acc && pwrite) begin
            if (paddr == 12'h154) rxf_q <= pwdata[7:0];
            if (paddr == 12'h15c) txf_q <= pwdata[7:0];
            if (paddr == 12'h148) pre_q <= pwdata[7:6];
        end
    end
    ////////////////////////////////////////////////////////////////////////////////
    AST_RXFINE: assert property (rd && paddr == 12'h154 |-> prdata[7:0] == rxf_q)
        else $error("receive fine divider readback differs from last write");
    AST_TXFINE: assert property (rd && paddr == 12'h15c |-> prdata[7:0] == txf_q)
        else $error("transmit fine divider readback differs from last write");
    AST_PRESCALE: assert property (rd && paddr == 12'h148 |-> prdata[7:6] == pre_q)
        else $error("coarse prescale readback differs");
    AST_UNMAPPED: assert property (acc && paddr == 12'h158 |-> pslverr)
        else $error("unmapped access not flagged");
    AST_UPPER: assert property (rd |-> prdata[31:8] == 24'h0)
        else $error("read data above byte not zero");
    AST_READY: assert property (psel && penable |-> pready)
        else $error("access phase without ready");
    AST_IDLE: assert property (!$past(presetn) |-> txd)
        else $error("line not idle after reset");
    // Any bit lasts 16 ticks of at least one cycle each
    AST_LOW_HOLD: assert property ($fell(txd) |=> !txd [*8])
        else $error("low level on line too short");
    AST_HIGH_HOLD: assert property ($rose(txd) |=> txd [*8])
        else $error("high level on line too short");
endmodule
bind sbc_serial sbc_serial_assertions #(.FIFO_DEPTH(FIFO_DEPTH)) u_chk (
    .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .rxd(rxd), .txd(txd));

// File: sbc_remote_node.sv
// Remote asynchronous node: frame receiver on txd and frame sender on rxd
`timescale 1ns/1ps
module sbc_remote_node (
    // Clock and bit length in cycles
    input wire logic pclk,
    input wire logic [31:0] bit_cyc,
    // Line
    input wire logic txd,
    output logic rxd
);
    logic [7:0] got;
    int n_got;
    // Line rests high between frames, as an idle asynchronous line does
    initial begin
        rxd = 1'b1;
        n_got = 0;
    end
    ////////////////////////////////////////////////////////////////////////////////
    // Mid-bit sampling, LSB first; count taken at mid stop bit
    always begin
        @(negedge txd);
        repeat (bit_cyc / 2) @(posedge pclk);
        for (int i = 0; i < 8; i++) begin
            repeat (bit_cyc) @(posedge pclk);
            got[i] = txd;
        end
        repeat (bit_cyc) @(posedge pclk);
        n_got++;
    end
    // Start, eight data bits LSB first, stop
    task send(input logic [7:0] b);
        logic [9:0] f;
        f = {1'b1, b, 1'b0};
        for (int i = 0; i < 10; i++) begin
            @(posedge pclk);
            rxd <= f[i];
            repeat (bit_cyc - 1) @(posedge pclk);
        end
        repeat (4) @(posedge pclk);
    endtask
endmodule

// File: async_serial_baud_and_control_tb.sv
// Testbench: register, rate, transmit, receive, mute and buffer checks
`timescale 1ns/1ps
module async_serial_baud_and_control_tb;
    import sbc_pkg::*;
    logic pclk, presetn, psel, penable, pwrite, pready, pslverr, rxd, txd;
    logic [11:0] paddr;
    logic [31:0] pwdata, prdata;
    logic [7:0] q;
    int bit_cyc, n_errors, n_tests, base, c, s;
    int fac[4];
    sbc_serial uut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .rxd(rxd), .txd(txd));
    sbc_remote_node remote (.pclk(pclk), .bit_cyc(bit_cyc), .txd(txd), .rxd(rxd));
    initial begin
        pclk = 1'b0;
        forever #5 pclk = ~pclk;
    end
    ////////////////////////////////////////////////////////////////////////////////
    task stop_test;
        if (n_errors == 0 && n_tests > 0) $display("NO MISMATCHES");
        else $display("MISMATCHES SEEN");
        $finish;
    endtask
    task chk(input string name, input logic [7:0] exp, input logic [7:0] got);
        n_tests++;
        if (got !== exp) begin
            $display("Error %s expected %h seen %h", name, exp, got);
            n_errors++;
        end
    endtask
    // One APB transfer, held until pready at an edge, then one idle cycle
    task xfer(input logic wr, input logic [11:0] a, input logic [7:0] d);
        int n;
        psel <= 1'b1;
        pwrite <= wr;
        paddr <= a;
        pwdata <= {24'h0, d};
        @(posedge pclk);
        penable <= 1'b1;
        for (n = 0; n < 50; n++) begin
            @(posedge pclk);
            if (pready === 1'b1) break;
        end
        q = prdata[7:0];
        psel <= 1'b0;
        penable <= 1'b0;
        if (n == 50) begin
            n_errors++;
            stop_test();
        end
        @(posedge pclk);
    endtask
    task rdc(input string name, input logic [11:0] a, input logic [7:0] exp);
        xfer(1'b0, a, 8'h00);
        chk(name, exp, q);
    endtask
    // Bounded wait for the remote node to count frames
    task wait_got(input int n);
        for (int k = 0; k < 30000 && remote.n_got < n; k++) @(posedge pclk);
        if (remote.n_got < n) begin
            n_errors++;
            stop_test();
        end
    endtask
    ////////////////////////////////////////////////////////////////////////////////
    initial begin
        {presetn, psel, penable, pwrite, paddr, pwdata, n_errors, n_tests} = '0;
        bit_cyc = 16;
        fac = '{1, 3, 4, 13};
        repeat (5) @(posedge pclk);
        presetn <= 1'b1;
        @(posedge pclk);
        // Reset values and an unmapped place
        rdc("control", 12'h150, 8'h00);
        rdc("rx fine", 12'h154, 8'h00);
        rdc("tx fine", 12'h15c, 8'h00);
        rdc("status", 12'h140, 8'hc0);
        xfer(1'b0, 12'h148, 8'h00);
        chk("prescale", 8'h00, q & 8'hc0);
        rdc("unmapped", 12'h158, 8'h00);
        // Every transmit divisor code, then coarse codes 1 to 3 at divisor code 1, measured on the line
        xfer(1'b1, 12'h150, 8'h08);
        for (int k = 0; k < 11; k++) begin
            c = (k < 8) ? 0 : k - 7;
            s = (k < 8) ? k : 1;
            bit_cyc = (16 * fac[c]) << s;
            xfer(1'b1, 12'h148, {c[1:0], s[2:0], 3'b000});
            base = remote.n_got;
            xfer(1'b1, 12'h144, 8'h96 ^ k[7:0]);
            wait_got(base + 1);
            chk("tx byte", 8'h96 ^ k[7:0], remote.got);
        end
        // Fine value overrides the slow coarse setting
        bit_cyc = 48;
        xfer(1'b1, 12'h15c, 8'h03);
        base = remote.n_got;
        xfer(1'b1, 12'h144, 8'h3c);
        wait_got(base + 1);
        chk("fine tx byte", 8'h3c, remote.got);
        // Fill past capacity: one in the shifter, eight held, the last dropped
        bit_cyc = 16;
        xfer(1'b1, 12'h15c, 8'h01);
        base = remote.n_got;
        for (int k = 0; k < 10; k++) xfer(1'b1, 12'h144, k[7:0]);
        xfer(1'b0, 12'h140, 8'h00);
        chk("fifo room", 8'h00, q & 8'h80);
        wait_got(base + 9);
        repeat (300) @(posedge pclk);
        chk("frame count", 8'd9, 8'(remote.n_got - base));
        chk("last byte", 8'h08, remote.got);
        // Break while set; line returns to idle after the trailing break
        xfer(1'b1, 12'h150, 8'h09);
        repeat (100) @(posedge pclk);
        chk("break line", 8'h00, {7'h0, txd});
        xfer(1'b1, 12'h150, 8'h08);
        repeat (150) @(posedge pclk);
        chk("break 2", 8'h00, {7'h0, txd});
        repeat (450) @(posedge pclk);
        chk("idle line", 8'h01, {7'h0, txd});
        // Receive at a conventional rate, then at a fine rate
        xfer(1'b1, 12'h150, 8'h0c);
        bit_cyc = 32;
        for (int j = 0; j < 2; j++) begin
            xfer(1'b1, 12'h148, (j == 0) ? 8'h01 : 8'h03);
            xfer(1'b1, 12'h154, (j == 0) ? 8'h00 : 8'h02);
            remote.send(8'hc3 ^ j[7:0]);
            xfer(1'b0, 12'h140, 8'h00);
            chk("rx full", 8'h20, q & 8'h20);
            rdc("rx data", 12'h144, 8'hc3 ^ j[7:0]);
        end
        // Receiver disabled ignores the line
        xfer(1'b1, 12'h150, 8'h08);
        remote.send(8'h5a);
        xfer(1'b0, 12'h140, 8'h00);
        chk("rx off", 8'h00, q & 8'h20);
        // Muted, address-mark wake-up, then idle-line wake-up
        xfer(1'b1, 12'h14c, 8'h08);
        xfer(1'b1, 12'h150, 8'h0e);
        remote.send(8'h05);
        xfer(1'b0, 12'h140, 8'h00);
        chk("muted", 8'h00, q & 8'h20);
        remote.send(8'h85);
        rdc("woken", 12'h150, 8'h0c);
        xfer(1'b0, 12'h140, 8'h00);
        chk("wake full", 8'h20, q & 8'h20);
        rdc("wake data", 12'h144, 8'h85);
        xfer(1'b1, 12'h14c, 8'h00);
        xfer(1'b1, 12'h150, 8'h0e);
        repeat (400) @(posedge pclk);
        rdc("idle wake", 12'h150, 8'h0c);
        stop_test();
    end
endmodule
